// ===== rtl/home_search_pkg.sv
/*
  Constants for the home search sequencer: register map, mode field layout,
  reset values, timing and sequencer states.
  Assumes a 10 MHz system clock and a single AHB-Lite master.
*/
// Behaviour
// - Step 3 drives at low speed until index
// - Clear pulse at index, step 4 after it
// - Index active at step 3 start: error, end
// - Search limit active at step 3 start: error
// - Search limit during step 3: abort, end
// - Step 4 emits exactly offset pulses, high speed
// - Step 4 direction flips for negative offset
// - After step 4 clear position unless disabled
// - Near-home level selectable; step 1 stops on it
// - Home level selectable; step 2 stops on it
// - Index level selectable; step 3 stops on it
// - Each step enable, default off; skip disabled
// - Per-step direction; defaults minus, minus, plus, plus
// - Option to use limit as home, default off
// - Clear enable off by default; owns shared output
// - Polarity 0 idles off pulses on; 1 reverse
// - Clear polarity inverse of general output command
// - Clear width 10 to 20000 us, default 10
// - Steps run in order; speeds high, low, low, high
package home_search_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned US_NS         = 1000;
  localparam int unsigned CYCLES_PER_US = US_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_MODE        = 8'h04;
  localparam logic [7:0] ADDR_OFFSET      = 8'h08;
  localparam logic [7:0] ADDR_LOW_PERIOD  = 8'h0c;
  localparam logic [7:0] ADDR_HIGH_PERIOD = 8'h10;
  localparam logic [7:0] ADDR_STATUS      = 8'h14;
  localparam logic [7:0] ADDR_POSITION    = 8'h18;

  // Control bits
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_GPO   = 8;

  // Mode fields
  localparam int unsigned MODE_W          = 18;
  localparam int unsigned F_NEAR_LVL      = 0;
  localparam int unsigned F_HOME_LVL      = 1;
  localparam int unsigned F_INDEX_LVL     = 2;
  localparam int unsigned F_STEP_EN       = 3;
  localparam int unsigned F_STEP_DIR      = 7;
  localparam int unsigned F_POS_CLR       = 11;
  localparam int unsigned F_USE_LIMIT     = 12;
  localparam int unsigned F_CLR_EN        = 13;
  localparam int unsigned F_CLR_LVL       = 14;
  localparam int unsigned F_CLR_WIDTH     = 15;
  // Levels low, steps off, dirs -,-,+,+, position clear on, width 10 us
  localparam logic [MODE_W-1:0] MODE_RESET = 18'h00e00;

  // Status bits
  localparam int unsigned ST_RUNNING = 0;
  localparam int unsigned ST_DONE    = 1;
  localparam int unsigned ST_ERROR   = 2;
  localparam int unsigned ST_ERRCODE = 4;
  localparam int unsigned ST_STATE   = 16;

  localparam logic [23:0] OFFSET_RESET      = 24'h000064;
  localparam logic [15:0] LOW_PERIOD_RESET  = 16'hc350;
  localparam logic [15:0] HIGH_PERIOD_RESET = 16'h01f4;

  localparam logic [1:0] ERR_NONE           = 2'h0;
  localparam logic [1:0] ERR_INDEX_AT_START = 2'h1;
  localparam logic [1:0] ERR_LIMIT_AT_START = 2'h2;
  localparam logic [1:0] ERR_LIMIT_DURING   = 2'h3;

  // Clear pulse widths in microseconds, by select code
  localparam int unsigned CLR_CNT_W = 24;
  localparam int unsigned CLR_WIDTH_US [8] = '{10, 20, 100, 200, 1000, 2000, 10000, 20000};

  typedef enum logic [11:0] {
    ST_IDLE     = 12'h001,
    ST_S1_RUN   = 12'h002,
    ST_S2_START = 12'h004,
    ST_S2_RUN   = 12'h008,
    ST_S2_BACK  = 12'h010,
    ST_S2_REV   = 12'h020,
    ST_S3_START = 12'h040,
    ST_S3_RUN   = 12'h080,
    ST_S3_CLR   = 12'h100,
    ST_S4_START = 12'h200,
    ST_S4_RUN   = 12'h400,
    ST_FINISH   = 12'h800
  } seq_state_t;

endpackage

// ===== rtl/clear_pulse_timer.sv
/*
  Timed pulse for the servo clear output.
  Assumes start is only raised while idle; a start during a pulse is ignored.
*/
`timescale 1ns/1ps
`default_nettype none
module clear_pulse_timer
  import home_search_pkg::*;
#(
  parameter int unsigned CYC_PER_US = CYCLES_PER_US
) (
  input  wire logic       clk_sys,   // System clock
  input  wire logic       rst,       // Synchronous reset
  input  wire logic       ce,        // Clock enable
  input  wire logic       start,     // Begin a pulse
  input  wire logic [2:0] width_sel, // Width select code
  output logic            active,    // Pulse in progress
  output logic            done       // One cycle after pulse ends
);

  logic [CLR_CNT_W-1:0] remain;
  logic [CLR_CNT_W-1:0] load;

  always_comb begin
    load = CLR_CNT_W'(CLR_WIDTH_US[width_sel] * CYC_PER_US - 1);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      active <= 1'b0;
      done   <= 1'b0;
      remain <= '0;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !active) begin
        active <= 1'b1;
        remain <= load;
      end else if (active) begin
        if (remain == '0) begin
          active <= 1'b0;
          done   <= 1'b1;
        end else begin
          remain <= remain - 1'b1;
        end
      end
    end
  end

  AST_WIDTH_MIN: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && start && !active) |=> active[*8]) else $error("Clear pulse shorter than minimum");

endmodule
`default_nettype wire

// ===== rtl/home_search_sequencer.sv
/*
  Single-axis home search sequencer with AHB-Lite register slave.
  Runs steps 1 to 4, makes step/direction pulses and the servo clear pulse.
  Assumes sensor and limit pins are already synchronous to clk_sys and that
  limit pins are asserted high. Acceleration ramps are not modelled: step 1
  stops at once rather than decelerating.
*/
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module home_search_sequencer
  import home_search_pkg::*;
#(
  parameter int unsigned CLR_CYCLES_PER_US = CYCLES_PER_US
) (
  input  wire logic        clk_sys,               // 10 MHz clock
  input  wire logic        rst,                   // Synchronous reset
  input  wire logic        ce,                    // Clock enable
  input  wire logic        hsel,                  // AHB select
  input  wire logic [31:0] haddr,                 // AHB address
  input  wire logic [1:0]  htrans,                // AHB transfer type
  input  wire logic        hwrite,                // AHB write
  input  wire logic [2:0]  hsize,                 // AHB size, word only
  input  wire logic [31:0] hwdata,                // AHB write data
  input  wire logic        hready,                // AHB bus ready
  output logic             hreadyout,             // AHB slave ready
  output logic [31:0]      hrdata,                // AHB read data
  output logic             hresp,                 // AHB response
  input  wire logic        near_home_input,       // Near-home sensor pin
  input  wire logic        home_input,            // Home sensor pin
  input  wire logic        index_input,           // Encoder index pin
  input  wire logic        limit_pos_input,       // Plus over-run limit
  input  wire logic        limit_neg_input,       // Minus over-run limit
  output logic             drive_pulse,           // One pulse per step
  output logic             drive_dir,             // 1 plus, 0 minus
  output logic             shared_general_output  // 1 output transistor on
);

  logic [MODE_W-1:0] mode;
  logic [23:0]       offset;
  logic [15:0]       low_period;
  logic [15:0]       high_period;
  logic              gpo;
  logic              start_req;
  logic              running;
  logic              done;
  logic              error;
  logic [1:0]        err_code;
  logic [31:0]       position;
  logic [23:0]       remaining;
  logic              s4_neg;
  logic [15:0]       rate_cnt;
  seq_state_t        state;

  logic       ap_valid;
  logic       ap_write;
  logic [7:0] ap_addr;

  logic [3:0] step_en;
  logic [3:0] step_dir;
  logic       near_act;
  logic       home_act;
  logic       idx_act;
  logic       lim1;
  logic       lim2;
  logic       lim3;
  logic       det2;
  logic       clr_en;
  logic       clr_lvl;
  logic       clr_active;
  logic       clr_done;
  logic       clr_start;
  logic       moving;
  logic       high_speed;
  logic       cur_dir;
  logic       halt;
  logic       tick;
  logic       emit;
  logic [15:0] period_m1;
  logic [31:0] rd_mux;

  assign step_en  = mode[F_STEP_EN +: 4];
  assign step_dir = mode[F_STEP_DIR +: 4];
  assign clr_en   = mode[F_CLR_EN];
  assign clr_lvl  = mode[F_CLR_LVL];

  // Level bit 1 means high is active
  assign near_act = ~(near_home_input ^ mode[F_NEAR_LVL]);
  assign home_act = ~(home_input ^ mode[F_HOME_LVL]);
  assign idx_act  = ~(index_input ^ mode[F_INDEX_LVL]);
  assign lim1 = step_dir[0] ? limit_pos_input : limit_neg_input;
  assign lim2 = step_dir[1] ? limit_pos_input : limit_neg_input;
  assign lim3 = step_dir[2] ? limit_pos_input : limit_neg_input;
  assign det2 = home_act | (mode[F_USE_LIMIT] & lim2);

  // AHB-Lite slave, zero wait states; stalls while ce is low
  assign hreadyout = ce;
  assign hresp     = 1'b0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= '0;
    end else if (ce) begin
      ap_valid <= hsel && htrans[1] && hready;
      ap_write <= hwrite;
      ap_addr  <= haddr[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode        <= MODE_RESET;
      offset      <= OFFSET_RESET;
      low_period  <= LOW_PERIOD_RESET;
      high_period <= HIGH_PERIOD_RESET;
      gpo         <= 1'b0;
      start_req   <= 1'b0;
    end else if (ce) begin
      start_req <= 1'b0;
      if (ap_valid && ap_write) begin
        case (ap_addr)
          ADDR_CTRL: begin
            start_req <= hwdata[CTRL_START];
            gpo       <= hwdata[CTRL_GPO];
          end
          ADDR_MODE:        mode        <= hwdata[MODE_W-1:0];
          ADDR_OFFSET:      offset      <= hwdata[23:0];
          ADDR_LOW_PERIOD:  low_period  <= hwdata[15:0];
          ADDR_HIGH_PERIOD: high_period <= hwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    case (haddr[7:0])
      ADDR_CTRL:        rd_mux[CTRL_GPO] = gpo;
      ADDR_MODE:        rd_mux[MODE_W-1:0] = mode;
      ADDR_OFFSET:      rd_mux = {{8{offset[23]}}, offset};
      ADDR_LOW_PERIOD:  rd_mux[15:0] = low_period;
      ADDR_HIGH_PERIOD: rd_mux[15:0] = high_period;
      ADDR_STATUS: begin
        rd_mux[ST_RUNNING]      = running;
        rd_mux[ST_DONE]         = done;
        rd_mux[ST_ERROR]        = error;
        rd_mux[ST_ERRCODE +: 2] = err_code;
        rd_mux[ST_STATE +: 12]  = state;
      end
      ADDR_POSITION:    rd_mux = position;
      default:          rd_mux = '0;
    endcase
  end

  // Read data captured at the address phase, so it stands in the data phase
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hrdata <= '0;
    end else if (ce && hsel && htrans[1] && hready && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // First enabled step at or after k; disabled ones are passed over
  function automatic seq_state_t step_entry(input logic [2:0] k, input logic [3:0] en);
    if (k <= 3'd1 && en[0]) return ST_S1_RUN;
    else if (k <= 3'd2 && en[1]) return ST_S2_START;
    else if (k <= 3'd3 && en[2]) return ST_S3_START;
    else if (en[3]) return ST_S4_START;
    else return ST_FINISH;
  endfunction

  always_comb begin
    moving     = 1'b0;
    high_speed = 1'b0;
    cur_dir    = 1'b0;
    halt       = 1'b0;
    case (state)
      ST_S1_RUN: begin
        moving     = 1'b1;
        high_speed = 1'b1;
        cur_dir    = step_dir[0];
        halt       = near_act | lim1;
      end
      ST_S2_START: cur_dir = step_dir[1];
      ST_S2_RUN: begin
        moving  = 1'b1;
        cur_dir = step_dir[1];
        halt    = det2 | lim2;
      end
      ST_S2_BACK: begin
        moving  = 1'b1;
        cur_dir = ~step_dir[1];
        halt    = ~det2;
      end
      ST_S2_REV: begin
        moving  = 1'b1;
        cur_dir = ~step_dir[1];
        halt    = det2;
      end
      ST_S3_START: cur_dir = step_dir[2];
      ST_S3_RUN: begin
        moving  = 1'b1;
        cur_dir = step_dir[2];
        halt    = idx_act | lim3;
      end
      ST_S4_RUN: begin
        moving     = 1'b1;
        high_speed = 1'b1;
        cur_dir    = step_dir[3] ^ s4_neg;
      end
      default: ;
    endcase
  end

  assign period_m1 = high_speed ? (high_period == '0 ? '0 : high_period - 1'b1)
                                : (low_period == '0 ? '0 : low_period - 1'b1);
  assign tick      = moving && (rate_cnt >= period_m1);
  // Halt gates the pulse in the same cycle: no overshoot past the sensor
  assign emit      = tick && !halt;
  assign clr_start = (state == ST_S3_RUN) && idx_act && !lim3 && clr_en;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rate_cnt    <= '0;
      drive_pulse <= 1'b0;
      drive_dir   <= 1'b0;
    end else if (ce) begin
      drive_pulse <= emit;
      drive_dir   <= cur_dir;
      if (!moving || halt || tick) begin
        rate_cnt <= '0;
      end else begin
        rate_cnt <= rate_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      position <= '0;
    end else if (ce) begin
      if (state == ST_FINISH && mode[F_POS_CLR]) begin
        position <= '0;
      end else if (emit) begin
        position <= cur_dir ? position + 1'b1 : position - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      remaining <= '0;
      s4_neg    <= 1'b0;
    end else if (ce) begin
      if (state == ST_S4_START) begin
        s4_neg    <= offset[23];
        remaining <= offset[23] ? (~offset + 1'b1) : offset;
      end else if (state == ST_S4_RUN && emit) begin
        remaining <= remaining - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state    <= ST_IDLE;
      running  <= 1'b0;
      done     <= 1'b0;
      error    <= 1'b0;
      err_code <= ERR_NONE;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            running  <= 1'b1;
            done     <= 1'b0;
            error    <= 1'b0;
            err_code <= ERR_NONE;
            state    <= step_entry(3'd1, step_en);
          end
        end
        ST_S1_RUN: begin
          if (near_act || lim1) begin
            state <= step_entry(3'd2, step_en);
          end
        end
        ST_S2_START: begin
          if (det2) begin
            state <= ST_S2_BACK;
          end else if (lim2) begin
            state <= ST_S2_REV;
          end else begin
            state <= ST_S2_RUN;
          end
        end
        ST_S2_RUN: begin
          if (det2) begin
            state <= step_entry(3'd3, step_en);
          end else if (lim2) begin
            state <= ST_S2_REV;
          end
        end
        ST_S2_REV: begin
          if (det2) begin
            state <= ST_S2_BACK;
          end
        end
        ST_S2_BACK: begin
          if (!det2) begin
            state <= ST_S2_START;
          end
        end
        ST_S3_START: begin
          if (idx_act) begin
            state    <= ST_IDLE;
            running  <= 1'b0;
            error    <= 1'b1;
            err_code <= ERR_INDEX_AT_START;
          end else if (lim3) begin
            state    <= ST_IDLE;
            running  <= 1'b0;
            error    <= 1'b1;
            err_code <= ERR_LIMIT_AT_START;
          end else begin
            state <= ST_S3_RUN;
          end
        end
        ST_S3_RUN: begin
          if (lim3) begin
            state    <= ST_IDLE;
            running  <= 1'b0;
            error    <= 1'b1;
            err_code <= ERR_LIMIT_DURING;
          end else if (idx_act) begin
            state <= clr_en ? ST_S3_CLR : step_entry(3'd4, step_en);
          end
        end
        ST_S3_CLR: begin
          if (clr_done) begin
            state <= step_entry(3'd4, step_en);
          end
        end
        ST_S4_START: begin
          state <= (offset == '0) ? ST_FINISH : ST_S4_RUN;
        end
        ST_S4_RUN: begin
          if (emit && remaining == 24'h000001) begin
            state <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          state   <= ST_IDLE;
          running <= 1'b0;
          done    <= 1'b1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  clear_pulse_timer #(
    .CYC_PER_US(CLR_CYCLES_PER_US)
  ) u_clear_timer (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .start    (clr_start),
    .width_sel(mode[F_CLR_WIDTH +: 3]),
    .active   (clr_active),
    .done     (clr_done)
  );

  // Polarity 0: idle off, pulse on; OUT command uses the opposite sense
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shared_general_output <= 1'b0;
    end else if (ce) begin
      shared_general_output <= clr_en ? (clr_active ^ clr_lvl) : gpo;
    end
  end

  AST_INDEX_STOPS: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && state == ST_S3_RUN && idx_act) |=> !drive_pulse) else $error("Pulse after index");
  AST_CLR_AT_INDEX: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && clr_start) |=> clr_active && state == ST_S3_CLR) else $error("Clear not started at index");
  AST_NO_S4_IN_CLR: assert property (@(posedge clk_sys) disable iff (rst)
    clr_active |-> !(state inside {ST_S4_START, ST_S4_RUN})) else $error("Step 4 during clear pulse");
  AST_INDEX_ERR: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && state == ST_S3_START && idx_act) |=> error && err_code == ERR_INDEX_AT_START && state == ST_IDLE)
    else $error("Index at step 3 start not flagged");
  AST_LIMIT_START_ERR: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && state == ST_S3_START && !idx_act && lim3) |=> error && err_code == ERR_LIMIT_AT_START)
    else $error("Limit at step 3 start not flagged");
  AST_LIMIT_RUN_ERR: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && state == ST_S3_RUN && lim3) |=> state == ST_IDLE && error && !drive_pulse)
    else $error("Limit during step 3 not aborted");
  AST_S4_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && state == ST_S4_RUN && emit && remaining == 24'h000001) |=> state == ST_FINISH && drive_pulse)
    else $error("Step 4 pulse count wrong");
  AST_S4_DIR: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && state == ST_S4_RUN) |=> drive_dir == (step_dir[3] ^ s4_neg)) else $error("Step 4 direction wrong");
  AST_POS_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && state == ST_FINISH && mode[F_POS_CLR]) |=> position == '0 && done) else $error("Position not cleared");
  AST_CLR_IDLE_LEVEL: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && clr_en && !clr_active) |=> shared_general_output == $past(clr_lvl)) else $error("Shared output idle wrong");

endmodule
`default_nettype wire

// ===== verif/motor_axis_model.sv
/*
  Axis model: shaft position from step pulses, near-home, home, index and
  limit sensors. Near-home and home are active from their point downward.
  Assumes the bench moves trigger positions only between runs.
*/
`timescale 1ns/1ps
`default_nettype none
module motor_axis_model (
  input  wire logic clk_sys,         // Clock
  input  wire logic drive_pulse,     // Step pulse
  input  wire logic drive_dir,       // 1 plus
  input  wire logic idx_high,        // Sensor active level
  input  var  int   idx_pos,         // Index position
  input  var  int   near_at,         // Near-home from here down
  input  var  int   home_at,         // Home from here down
  input  var  int   lim_pos_at,      // Plus limit from here up
  input  var  int   lim_neg_at,      // Minus limit from here down
  output logic      near_home_input, // Near-home pin
  output logic      home_input,      // Home pin
  output logic      index_input,     // Index pin
  output logic      limit_pos_input, // Plus limit pin
  output logic      limit_neg_input, // Minus limit pin
  output var  int   pos              // Shaft position
);
  initial pos = 0;
  always @(posedge clk_sys) begin
    if (drive_pulse === 1'b1) pos <= drive_dir ? pos + 1 : pos - 1;
  end
  // Index only at one shaft position, like a real encoder mark
  assign index_input     = (pos == idx_pos) ? idx_high : ~idx_high;
  assign near_home_input = (pos <= near_at) ? idx_high : ~idx_high;
  assign home_input      = (pos <= home_at) ? idx_high : ~idx_high;
  assign limit_pos_input = pos >= lim_pos_at;
  assign limit_neg_input = pos <= lim_neg_at;
endmodule
`default_nettype wire

// ===== verif/home_search_sequencer_tb_top.sv
/*
  Bench for the home search sequencer: AHB-Lite master, axis model, pulse counters.
  Assumes sensor pins come from the axis model, all at one active level.
*/
`timescale 1ns/1ps
`default_nettype none
module home_search_sequencer_tb_top;
  import home_search_pkg::*;
  logic        clk_sys = 0, rst = 1, hsel = 0, hwrite = 0, idx_high = 0;
  logic        dp, dd, sgo, hro, hresp, ix, lp, ln, nh, hm;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  int idx_pos = 1000, near_at = -2000, home_at = -2000, lim_pos_at = 1000, lim_neg_at = -1000, pos;
  int bad_count = 0, n_checks = 0, cyc = 0, p_plus, p_minus, clr_cyc, p_in_clr, k, off, sel, lvl;
  int s1_len, s2_len;
  logic [7:0]  ra[7] = '{ADDR_MODE, ADDR_OFFSET, ADDR_LOW_PERIOD, ADDR_HIGH_PERIOD, ADDR_STATUS, ADDR_POSITION, 8'h1c};
  logic [31:0] rv[7] = '{32'h00e00, 32'h64, 32'hc350, 32'h1f4, 32'h10000, 32'h0, 32'h0};

  always #50 clk_sys = ~clk_sys;

  home_search_sequencer #(.CLR_CYCLES_PER_US(1)) i_home_search_sequencer (
    .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hro), .hreadyout(hro), .hrdata(hrdata), .hresp(hresp),
    .near_home_input(nh), .home_input(hm), .index_input(ix), .limit_pos_input(lp),
    .limit_neg_input(ln), .drive_pulse(dp), .drive_dir(dd), .shared_general_output(sgo));

  motor_axis_model i_motor_axis_model (
    .clk_sys(clk_sys), .drive_pulse(dp), .drive_dir(dd), .idx_high(idx_high), .idx_pos(idx_pos),
    .near_at(near_at), .home_at(home_at), .near_home_input(nh), .home_input(hm),
    .lim_pos_at(lim_pos_at), .lim_neg_at(lim_neg_at), .index_input(ix), .limit_pos_input(lp),
    .limit_neg_input(ln), .pos(pos));

  task automatic close_out();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Pulse and clear-pulse counters, plus the hang limit
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      close_out();
    end
    if (dp === 1'b1 && dd === 1'b1) p_plus++;
    if (dp === 1'b1 && dd === 1'b0) p_minus++;
    if (sgo !== lvl[0]) clr_cyc++;
    if (sgo !== lvl[0] && dp === 1'b1) p_in_clr++;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge clk_sys); while (hro !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hro !== 1'b1);
    q = hrdata;
  endtask

  function automatic logic [31:0] mk(input logic il, input logic cen, input logic cl, input logic pc,
                                     input logic [2:0] w, input logic s12);
    logic [31:0] m;
    m = 32'h0;
    m[F_STEP_EN +: 2] = {s12, s12};
    m[F_NEAR_LVL]   = il;
    m[F_HOME_LVL]   = il;
    m[F_STEP_EN+2]  = 1'b1;
    m[F_STEP_EN+3]  = 1'b1;
    m[F_STEP_DIR+2] = 1'b1;
    m[F_STEP_DIR+3] = 1'b1;
    m[F_INDEX_LVL]  = il;
    m[F_CLR_EN]     = cen;
    m[F_CLR_LVL]    = cl;
    m[F_POS_CLR]    = pc;
    m[F_CLR_WIDTH +: 3] = w;
    return m;
  endfunction

  // General output held on during every run: the clear function must own the pin
  task automatic run(input logic [31:0] mode);
    bus(1'b1, ADDR_MODE, mode, rd);
    bus(1'b1, ADDR_CTRL, 32'h101, rd);
    // Cleared only now: the shared output settles one cycle after the mode write
    p_plus = 0;
    p_minus = 0;
    clr_cyc = 0;
    p_in_clr = 0;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 500; i++) begin
      bus(1'b0, ADDR_STATUS, 32'h0, rd);
      if (rd[ST_RUNNING] === 1'b0) break;
    end
  endtask

  initial begin
    void'($urandom(55));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0, rd);
      chk("reset value", rv[i], rd);
    end
    chk("bus response", 32'h0, {31'h0, hresp});
    bus(1'b1, ADDR_CTRL, 32'h100, rd);
    repeat (2) @(negedge clk_sys);
    chk("general output on", 32'h1, {31'h0, sgo});
    bus(1'b1, ADDR_LOW_PERIOD, 32'h4, rd);
    bus(1'b1, ADDR_HIGH_PERIOD, 32'h2, rd);
    for (int r = 0; r < 2; r++) begin
      k = 1 + $urandom % 8;
      off = int'($urandom % 21) - 10;
      if (off == 0) off = 5;
      sel = $urandom % 3;
      s1_len = 1 + $urandom % 8;
      s2_len = 1 + $urandom % 8;
      @(negedge clk_sys);
      lvl = r;
      idx_high = r[0];
      near_at = pos - s1_len;
      home_at = pos - s1_len - s2_len;
      idx_pos = pos + k - r * (s1_len + s2_len);
      lim_pos_at = pos + 1000;
      lim_neg_at = pos - 1000;
      bus(1'b1, ADDR_OFFSET, off, rd);
      run(mk(r[0], 1'b1, r[0], r == 0, sel[2:0], r[0]));
      chk("status", 32'h10002, rd);
      chk("plus pulses", k + (off > 0 ? off : 0), p_plus);
      chk("minus pulses", r * (s1_len + s2_len) + (off < 0 ? -off : 0), p_minus);
      chk("clear width", CLR_WIDTH_US[sel], clr_cyc);
      chk("pulses in clear", 0, p_in_clr);
      bus(1'b0, ADDR_POSITION, 32'h0, rd);
      chk("position", r == 0 ? 0 : k + off - s1_len - s2_len, rd);
    end
    for (int e = 1; e < 4; e++) begin
      @(negedge clk_sys);
      idx_high = 1'b0;
      idx_pos = e == 1 ? pos : pos + 50;
      lim_pos_at = e == 2 ? pos : (e == 3 ? pos + 3 : pos + 1000);
      run(mk(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 1'b0));
      chk("error status", 32'h10004 | (e << 4), rd & 32'hffff_fffd);
      chk("search pulses", e == 3 ? 3 : 0, p_plus + p_minus);
    end
    close_out();
  end
endmodule
`default_nettype wire
